//--- fgr_pkg.sv
package fgr_pkg;

    // Clock and refresh timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_REFI_BASE_NS = 7800;
    localparam int unsigned REFI_BASE_CYC = T_REFI_BASE_NS / CLK_PERIOD_NS;
    localparam int unsigned T_RFC1_NS = 350;
    localparam int unsigned T_RFC2_NS = 260;
    localparam int unsigned T_RFC4_NS = 160;
    localparam int unsigned T_XS_NS = T_RFC1_NS + 10;
    localparam int unsigned RFC1_CYC = (T_RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RFC2_CYC = (T_RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RFC4_CYC = (T_RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned XS_CYC = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MRS_WAIT_CYC = 24;
    localparam int unsigned MAX_OWED = 8;
    localparam int unsigned WAIT_W = 8;

    // Register offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Control field positions
    localparam int unsigned CTRL_RATE_LSB = 0;
    localparam int unsigned CTRL_TCR_BIT = 3;
    localparam int unsigned CTRL_REF_EN_BIT = 4;
    localparam int unsigned CTRL_OTF_SUB_BIT = 5;
    localparam int unsigned CTRL_SR_BIT = 6;
    localparam int unsigned CTRL_APPLY_BIT = 8;

    // Refresh mode field encodings
    localparam logic [2:0] MODE_FIXED_1X = 3'h0;
    localparam logic [2:0] MODE_FIXED_2X = 3'h1;
    localparam logic [2:0] MODE_FIXED_4X = 3'h2;
    localparam logic [2:0] MODE_OTF_1X2X = 3'h5;
    localparam logic [2:0] MODE_OTF_1X4X = 3'h6;

    // Refresh rate family
    typedef enum logic [1:0] {RATE_1X = 2'h0, RATE_2X = 2'h1, RATE_4X = 2'h2} rate_t;

    // Command toward the memory
    typedef enum logic [2:0] {
        OP_NOP = 3'h0, OP_REF = 3'h1, OP_MRS = 3'h2, OP_SRE = 3'h3, OP_SRX = 3'h4
    } dram_op_t;

    typedef struct packed {
        dram_op_t op;
        logic bg0;
        logic [2:0] rate_field;
        logic tcr_en;
    } dram_cmd_t;

    // Sequencer states, Gray along idle-busy-self
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_BUSY = 2'h1, ST_SELF = 2'h3} ctl_state_t;

    // Sub-rate family of a mode field
    function automatic rate_t rate_family(input logic [2:0] mode);
        rate_t r;
        r = RATE_1X;
        if (mode == MODE_FIXED_2X || mode == MODE_OTF_1X2X) begin
            r = RATE_2X;
        end else if (mode == MODE_FIXED_4X || mode == MODE_OTF_1X4X) begin
            r = RATE_4X;
        end
        return r;
    endfunction : rate_family

    // Only five encodings are defined
    function automatic logic mode_valid(input logic [2:0] mode);
        return (mode == MODE_FIXED_1X) || (mode == MODE_FIXED_2X) || (mode == MODE_FIXED_4X)
            || (mode == MODE_OTF_1X2X) || (mode == MODE_OTF_1X4X);
    endfunction : mode_valid

endpackage : fgr_pkg

//--- refresh_interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
module refresh_interval_timer #(
    parameter int unsigned BASE_CYC = fgr_pkg::REFI_BASE_CYC,
    parameter int unsigned CNT_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic hold,
    input wire fgr_pkg::rate_t rate,
    // One-cycle pulse per elapsed interval
    output logic tick
);

    // Refuse intervals that do not fit or cannot divide by four
    if (BASE_CYC < 8 || BASE_CYC % 4 != 0 || BASE_CYC >= (1 << CNT_W)) begin : g_bad_base
        $error("refresh_interval_timer: BASE_CYC out of range");
    end

    logic [CNT_W-1:0] cnt_ff; // Cycles into current interval
    fgr_pkg::rate_t last_rate_ff; // Rate of the running interval
    logic [CNT_W-1:0] period; // Interval length at current rate
    logic restart; // Start a fresh interval

    assign period = CNT_W'(BASE_CYC) >> rate;
    assign restart = hold || (rate != last_rate_ff);

    // Interval counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            last_rate_ff <= fgr_pkg::RATE_1X;
            tick <= 1'b0;
        end else begin
            last_rate_ff <= rate;
            if (restart) begin
                // New interval counts from the next cycle
                cnt_ff <= '0;
                tick <= 1'b0;
            end else if (cnt_ff == period - CNT_W'(1)) begin
                cnt_ff <= '0;
                tick <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + CNT_W'(1);
                tick <= 1'b0;
            end
        end
    end

endmodule : refresh_interval_timer
`default_nettype wire

//--- fgr_refresh_ctl.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fgr_refresh_ctl #(
    parameter int unsigned REFI_BASE_CYC = fgr_pkg::REFI_BASE_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command toward the memory
    output fgr_pkg::dram_cmd_t dram_cmd
);

    // Counters must hold the longest wait
    if (fgr_pkg::XS_CYC >= (1 << fgr_pkg::WAIT_W)
        || fgr_pkg::MRS_WAIT_CYC >= (1 << fgr_pkg::WAIT_W)) begin : g_bad_wait
        $error("fgr_refresh_ctl: wait counter too narrow");
    end

    // Decision of the idle sequencer
    typedef enum logic [2:0] {
        ACT_NONE, ACT_EXTRA, ACT_PAD, ACT_MRS, ACT_REF, ACT_SRE, ACT_SRX
    } act_t;

    // Software control fields
    logic [2:0] rate_req_ff; // Requested mode field
    logic tcr_req_ff; // Temperature refresh wanted
    logic ref_en_ff; // Periodic refresh enabled
    logic otf_sub_ff; // On-the-fly: use sub-rate refreshes
    logic sr_req_ff; // Self refresh wanted
    logic apply_pend_ff; // Mode write waiting

    // Sequencer state
    fgr_pkg::ctl_state_t state_ff; // Idle, busy or self refresh
    logic [fgr_pkg::WAIT_W-1:0] wait_ff; // Cycles left in busy
    logic [2:0] cur_mode_ff; // Mode written to the memory
    logic cur_tcr_ff; // Temperature refresh written
    logic [1:0] sub_cnt_ff; // Sub-rate refreshes modulo two or four
    logic [2:0] extra_cnt_ff; // Extra refreshes owed after exit
    logic extra_norm_ff; // Extras are normal-rate ones
    logic [3:0] owed_ff; // Postponed periodic refreshes

    // APB helpers
    logic access; // Access phase
    logic fire; // Transfer completes this edge
    logic mapped; // Address decodes

    // Decision helpers
    act_t act; // Chosen action in this cycle
    fgr_pkg::rate_t fam; // Family of the current mode
    fgr_pkg::rate_t new_fam; // Family of the requested mode
    fgr_pkg::rate_t tmr_rate; // Rate the timer runs at
    logic on_the_fly_rate_select; // Current mode is on-the-fly
    logic sub_open; // Sub-rate count not at a boundary
    logic rate_chg; // Requested write changes the rate
    logic reg_sub; // Periodic refresh would be sub-rate
    logic tick; // Interval elapsed

    // APB decode
    assign access = psel && penable;
    assign fire = access && pready;
    assign mapped = (paddr == fgr_pkg::CTRL_OFS) || (paddr == fgr_pkg::STATUS_OFS);

    // Slave answers one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access && !pready;
            if (access && !pready) begin
                // Reserved mode encodings are refused with an error
                pslverr <= !mapped || (pwrite && paddr == fgr_pkg::CTRL_OFS
                    && !fgr_pkg::mode_valid(pwdata[fgr_pkg::CTRL_RATE_LSB +: 3]));
                if (paddr == fgr_pkg::CTRL_OFS) begin
                    prdata <= {25'h0, sr_req_ff, otf_sub_ff, ref_en_ff, tcr_req_ff,
                        rate_req_ff};
                end else if (paddr == fgr_pkg::STATUS_OFS) begin
                    prdata <= {14'h0, state_ff, owed_ff, 1'b0, extra_cnt_ff, apply_pend_ff,
                        (state_ff == fgr_pkg::ST_SELF), sub_cnt_ff, cur_tcr_ff, cur_mode_ff};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control register; an erroneous write changes nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_req_ff <= fgr_pkg::CTRL_RESET[fgr_pkg::CTRL_RATE_LSB +: 3];
            tcr_req_ff <= fgr_pkg::CTRL_RESET[fgr_pkg::CTRL_TCR_BIT];
            ref_en_ff <= fgr_pkg::CTRL_RESET[fgr_pkg::CTRL_REF_EN_BIT];
            otf_sub_ff <= fgr_pkg::CTRL_RESET[fgr_pkg::CTRL_OTF_SUB_BIT];
            sr_req_ff <= fgr_pkg::CTRL_RESET[fgr_pkg::CTRL_SR_BIT];
        end else if (fire && pwrite && !pslverr && paddr == fgr_pkg::CTRL_OFS) begin
            rate_req_ff <= pwdata[fgr_pkg::CTRL_RATE_LSB +: 3];
            tcr_req_ff <= pwdata[fgr_pkg::CTRL_TCR_BIT];
            ref_en_ff <= pwdata[fgr_pkg::CTRL_REF_EN_BIT];
            otf_sub_ff <= pwdata[fgr_pkg::CTRL_OTF_SUB_BIT];
            sr_req_ff <= pwdata[fgr_pkg::CTRL_SR_BIT];
        end
    end

    // Apply flag; a new request beats the clear of the old one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apply_pend_ff <= 1'b0;
        end else if (fire && pwrite && !pslverr && paddr == fgr_pkg::CTRL_OFS
            && pwdata[fgr_pkg::CTRL_APPLY_BIT]) begin
            apply_pend_ff <= 1'b1;
        end else if (act == ACT_MRS) begin
            apply_pend_ff <= 1'b0;
        end
    end

    // Mode classification
    assign fam = fgr_pkg::rate_family(cur_mode_ff);
    assign new_fam = fgr_pkg::rate_family(rate_req_ff);
    assign on_the_fly_rate_select = cur_mode_ff[2];
    assign sub_open = (fam == fgr_pkg::RATE_2X) ? sub_cnt_ff[0]
        : (fam == fgr_pkg::RATE_4X) ? (sub_cnt_ff != 2'h0) : 1'b0;
    assign rate_chg = (new_fam != fam);
    assign reg_sub = (fam != fgr_pkg::RATE_1X) && (!on_the_fly_rate_select || otf_sub_ff || sub_open);
    assign tmr_rate = (on_the_fly_rate_select && !otf_sub_ff) ? fgr_pkg::RATE_1X : fam;

    // Choose one action per idle cycle
    always_comb begin
        act = ACT_NONE;
        if (state_ff == fgr_pkg::ST_IDLE) begin
            if (extra_cnt_ff != 3'h0) begin
                act = ACT_EXTRA;
            end else if (apply_pend_ff && rate_chg && sub_open) begin
                act = ACT_PAD;
            end else if (apply_pend_ff) begin
                act = ACT_MRS;
            end else if (ref_en_ff && owed_ff != 4'h0) begin
                act = ACT_REF;
            end else if (sr_req_ff) begin
                act = ACT_SRE;
            end
        end else if (state_ff == fgr_pkg::ST_SELF && !sr_req_ff) begin
            act = ACT_SRX;
        end
    end

    // Interval source, held at zero in self refresh or when disabled
    refresh_interval_timer #(
        .BASE_CYC(REFI_BASE_CYC),
        .CNT_W(12)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .hold(!ref_en_ff || state_ff == fgr_pkg::ST_SELF),
        .rate(tmr_rate),
        .tick(tick)
    );

    // Postponed refresh count; padding also pays off a due refresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owed_ff <= 4'h0;
        end else begin
            if (tick && !(act == ACT_REF || (act == ACT_PAD && owed_ff != 4'h0))) begin
                if (owed_ff < 4'(fgr_pkg::MAX_OWED)) begin
                    owed_ff <= owed_ff + 4'h1;
                end
            end else if (!tick && (act == ACT_REF || (act == ACT_PAD && owed_ff != 4'h0))) begin
                owed_ff <= owed_ff - 4'h1;
            end
        end
    end

    // Sequencer: commands, waits and sub-rate bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= fgr_pkg::ST_IDLE;
            wait_ff <= '0;
            cur_mode_ff <= fgr_pkg::MODE_FIXED_1X;
            cur_tcr_ff <= 1'b0;
            sub_cnt_ff <= 2'h0;
            extra_cnt_ff <= 3'h0;
            extra_norm_ff <= 1'b0;
            dram_cmd <= '{op: fgr_pkg::OP_NOP, bg0: 1'b0, rate_field: 3'h0, tcr_en: 1'b0};
        end else begin
            dram_cmd <= '{op: fgr_pkg::OP_NOP, bg0: 1'b0, rate_field: cur_mode_ff,
                tcr_en: cur_tcr_ff};
            case (act)
                ACT_EXTRA: begin
                    dram_cmd.op <= fgr_pkg::OP_REF;
                    dram_cmd.bg0 <= 1'b0;
                    extra_cnt_ff <= extra_cnt_ff - 3'h1;
                    state_ff <= fgr_pkg::ST_BUSY;
                    if (extra_norm_ff || fam == fgr_pkg::RATE_1X) begin
                        wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::RFC1_CYC - 1);
                    end else if (fam == fgr_pkg::RATE_2X) begin
                        wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::RFC2_CYC - 1);
                    end else begin
                        wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::RFC4_CYC - 1);
                    end
                end
                ACT_PAD, ACT_REF: begin
                    dram_cmd.op <= fgr_pkg::OP_REF;
                    dram_cmd.bg0 <= on_the_fly_rate_select && (act == ACT_PAD || reg_sub);
                    state_ff <= fgr_pkg::ST_BUSY;
                    if (act == ACT_REF && !reg_sub) begin
                        sub_cnt_ff <= 2'h0;
                        wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::RFC1_CYC - 1);
                    end else if (fam == fgr_pkg::RATE_2X) begin
                        sub_cnt_ff <= {1'b0, ~sub_cnt_ff[0]};
                        wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::RFC2_CYC - 1);
                    end else begin
                        sub_cnt_ff <= sub_cnt_ff + 2'h1;
                        wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::RFC4_CYC - 1);
                    end
                end
                ACT_MRS: begin
                    dram_cmd.op <= fgr_pkg::OP_MRS;
                    dram_cmd.rate_field <= rate_req_ff;
                    dram_cmd.tcr_en <= tcr_req_ff && (rate_req_ff == fgr_pkg::MODE_FIXED_1X);
                    cur_mode_ff <= rate_req_ff;
                    cur_tcr_ff <= tcr_req_ff && (rate_req_ff == fgr_pkg::MODE_FIXED_1X);
                    if (rate_chg) begin
                        sub_cnt_ff <= 2'h0;
                    end
                    state_ff <= fgr_pkg::ST_BUSY;
                    wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::MRS_WAIT_CYC - 1);
                end
                ACT_SRE: begin
                    dram_cmd.op <= fgr_pkg::OP_SRE;
                    state_ff <= fgr_pkg::ST_SELF;
                    extra_norm_ff <= on_the_fly_rate_select;
                    if (!sub_open) begin
                        extra_cnt_ff <= 3'h0;
                    end else if (on_the_fly_rate_select) begin
                        extra_cnt_ff <= 3'h1;
                    end else if (fam == fgr_pkg::RATE_2X) begin
                        extra_cnt_ff <= 3'h2;
                    end else begin
                        extra_cnt_ff <= 3'h4;
                    end
                end
                ACT_SRX: begin
                    dram_cmd.op <= fgr_pkg::OP_SRX;
                    sub_cnt_ff <= 2'h0;
                    state_ff <= fgr_pkg::ST_BUSY;
                    wait_ff <= fgr_pkg::WAIT_W'(fgr_pkg::XS_CYC - 1);
                end
                default: begin
                    if (state_ff == fgr_pkg::ST_BUSY) begin
                        if (wait_ff == '0) begin
                            state_ff <= fgr_pkg::ST_IDLE;
                        end else begin
                            wait_ff <= wait_ff - fgr_pkg::WAIT_W'(1);
                        end
                    end
                end
            endcase
        end
    end

    // Checks on the command stream
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence exit_owing_s;
        dram_cmd.op == fgr_pkg::OP_SRX && extra_cnt_ff != 3'h0;
    endsequence
    sequence extra_ref_s;
        dram_cmd.op == fgr_pkg::OP_REF;
    endsequence

    tcr_normal_only_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_MRS && dram_cmd.tcr_en) |-> dram_cmd.rate_field == 3'h0)
        else $error("temperature refresh with non-normal mode");
    tcr_forced_off_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_MRS && dram_cmd.rate_field != 3'h0) |-> !cur_tcr_ff)
        else $error("temperature refresh left on");
    otf2_even_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_REF && !dram_cmd.bg0
            && cur_mode_ff == fgr_pkg::MODE_OTF_1X2X) |-> !$past(sub_cnt_ff[0]))
        else $error("odd double refreshes before normal");
    otf4_fours_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_REF && !dram_cmd.bg0
            && cur_mode_ff == fgr_pkg::MODE_OTF_1X4X) |-> $past(sub_cnt_ff) == 2'h0)
        else $error("quad refreshes not in fours before normal");
    mrs_even_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_MRS && $past(fam) == fgr_pkg::RATE_2X
            && fgr_pkg::rate_family(dram_cmd.rate_field) != fgr_pkg::RATE_2X)
        |-> !$past(sub_cnt_ff[0]))
        else $error("rate write after odd double refreshes");
    mrs_fours_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_MRS && $past(fam) == fgr_pkg::RATE_4X
            && fgr_pkg::rate_family(dram_cmd.rate_field) != fgr_pkg::RATE_4X)
        |-> $past(sub_cnt_ff) == 2'h0)
        else $error("rate write after partial quad group");
    ref_gap_hold_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_REF) |=> (dram_cmd.op == fgr_pkg::OP_NOP) [*8])
        else $error("command inside refresh cycle time");
    exit_extra_a: assert property (
        exit_owing_s |-> ##[37:60] extra_ref_s)
        else $error("extra refresh missing after exit");
    extra_no_credit_a: assert property (
        (act == ACT_EXTRA) |=> owed_ff >= $past(owed_ff))
        else $error("extra refresh reduced postponed count");
    sub_clear_a: assert property (
        (dram_cmd.op == fgr_pkg::OP_SRX) |-> sub_cnt_ff == 2'h0 ##1 state_ff == fgr_pkg::ST_BUSY)
        else $error("counter not cleared on exit");
    fixed2_extra_a: assert property (
        (act == ACT_SRE && cur_mode_ff == fgr_pkg::MODE_FIXED_2X && sub_cnt_ff[0])
        |=> extra_cnt_ff == 3'h2)
        else $error("two double extras not owed after entry");
    fixed4_extra_a: assert property (
        (act == ACT_SRE && cur_mode_ff == fgr_pkg::MODE_FIXED_4X && sub_cnt_ff != 2'h0)
        |=> extra_cnt_ff == 3'h4)
        else $error("four quad extras not owed after entry");

endmodule : fgr_refresh_ctl
`default_nettype wire

//--- fgr_dram_model.sv
`timescale 1ns/100ps
`default_nettype none
module fgr_dram_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command stream, error tally and refresh count
    input wire fgr_pkg::dram_cmd_t dram_cmd,
    output logic [7:0] viol_ff,
    output logic [15:0] refs_ff
);
    logic [2:0] mode_ff; // Current mode field
    logic [1:0] sub_ff; // Sub-rate refreshes mod 4
    logic [2:0] xtra_ff; // Extras owed after exit
    logic ent_ff; // Count broken at entry
    logic [7:0] gap_ff; // Cycles still busy
    int fam;
    int nf;
    logic sub;
    logic bad;
    always_comb begin
        fam = (mode_ff == 3'h1 || mode_ff == 3'h5) ? 2 : (mode_ff[1] ? 4 : 1);
        nf = (dram_cmd.rate_field == 3'h1 || dram_cmd.rate_field == 3'h5) ? 2
            : (dram_cmd.rate_field[1] ? 4 : 1);
        sub = (mode_ff == 3'h1 || mode_ff == 3'h2) || (mode_ff[2] && dram_cmd.bg0);
    end
    // Device state and rule watch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_ff, sub_ff, xtra_ff, ent_ff, gap_ff, viol_ff, refs_ff} <= '0;
        end else begin
            bad = (dram_cmd.op != fgr_pkg::OP_NOP) && (gap_ff != 8'h0);
            gap_ff <= (gap_ff != 8'h0) ? gap_ff - 8'h1 : 8'h0;
            case (dram_cmd.op)
                fgr_pkg::OP_REF: begin
                    refs_ff <= refs_ff + 16'h1;
                    xtra_ff <= (xtra_ff != 3'h0) ? xtra_ff - 3'h1 : 3'h0;
                    gap_ff <= sub ? 8'((fam == 2 ? fgr_pkg::RFC2_CYC : fgr_pkg::RFC4_CYC) - 1)
                        : 8'(fgr_pkg::RFC1_CYC - 1);
                    if (sub) begin
                        sub_ff <= sub_ff + 2'h1;
                    end else begin
                        if (32'(sub_ff) % fam != 0) bad = 1'b1;
                        sub_ff <= 2'h0;
                    end
                end
                fgr_pkg::OP_MRS: begin
                    if (nf != fam && 32'(sub_ff) % fam != 0) bad = 1'b1;
                    if (nf != fam) sub_ff <= 2'h0;
                    if (dram_cmd.tcr_en && dram_cmd.rate_field != 3'h0) bad = 1'b1;
                    mode_ff <= dram_cmd.rate_field;
                end
                fgr_pkg::OP_SRE: begin
                    ent_ff <= (32'(sub_ff) % fam != 0);
                    if (xtra_ff != 3'h0) bad = 1'b1;
                end
                fgr_pkg::OP_SRX: begin
                    xtra_ff <= ent_ff ? (mode_ff[2] ? 3'h1 : 3'(fam)) : 3'h0;
                    sub_ff <= 2'h0;
                    gap_ff <= 8'(fgr_pkg::XS_CYC - 1);
                end
                default: ;
            endcase
            if (bad) viol_ff <= viol_ff + 8'h1;
        end
    end
endmodule : fgr_dram_model
`default_nettype wire

//--- fgr_refresh_ctl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module fgr_refresh_ctl_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fgr_pkg::dram_cmd_t dram_cmd;
    logic [7:0] viol;
    logic [15:0] refs;
    int n_fail = 0;
    int total_checks = 0;
    int seed = 32'he78f9f75;
    logic [31:0] rd;
    logic er;
    logic [2:0] m;
    logic temperature_controlled_refresh;
    logic sr;
    logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    // Clock at 100 MHz
    always #5 pclk = ~pclk;
    // Interval long enough that owed refreshes drain, so self refresh can start
    fgr_refresh_ctl #(.REFI_BASE_CYC(160)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dram_cmd(dram_cmd));
    fgr_dram_model mem (.pclk(pclk), .presetn(presetn), .dram_cmd(dram_cmd), .viol_ff(viol),
        .refs_ff(refs));
    // Compare and tally
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Temperature refresh survives only in fixed normal mode
    function automatic logic exp_tcr(input logic t, input logic [2:0] mode);
        return t && (mode == fgr_pkg::MODE_FIXED_1X);
    endfunction : exp_tcr
    // One APB transfer, waits on pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // Watchdog against a hang; the full run needs about 10000 cycles
    initial begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, fgr_pkg::CTRL_OFS, 32'h0);
        chk("ctrl_reset", rd, fgr_pkg::CTRL_RESET);
        apb(1'b0, fgr_pkg::STATUS_OFS, 32'h0);
        chk("status_reset", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        // Reserved mode is refused whole
        apb(1'b1, fgr_pkg::CTRL_OFS, 32'h0000_0113);
        chk("reserved_err", {31'h0, er}, 32'h1);
        apb(1'b0, fgr_pkg::CTRL_OFS, 32'h0);
        chk("ctrl_kept", rd, 32'h0);
        // Random mode changes, some with self refresh
        for (int i = 0; i < 24; i++) begin
            m = modes[$unsigned($random(seed)) % 5];
            temperature_controlled_refresh = 1'($random(seed));
            sr = (i % 3 == 2);
            apb(1'b1, fgr_pkg::CTRL_OFS, {23'h0, 1'b1, 1'b0, sr, 1'($random(seed)), 1'b1, temperature_controlled_refresh, m});
            chk("write_err", {31'h0, er}, 32'h0);
            repeat (300) @(posedge pclk);
            apb(1'b0, fgr_pkg::STATUS_OFS, 32'h0);
            chk("mode", {29'h0, rd[2:0]}, {29'h0, m});
            chk("tcr_on", {31'h0, rd[3]}, {31'h0, exp_tcr(temperature_controlled_refresh, m)});
            chk("in_self", {31'h0, rd[6]}, {31'h0, sr});
            if (sr) begin
                apb(1'b1, fgr_pkg::CTRL_OFS, {27'h0, 1'b1, temperature_controlled_refresh, m});
                repeat (300) @(posedge pclk);
            end
            chk("dram_viol", {24'h0, viol}, 32'h0);
        end
        chk("refs_seen", {31'h0, refs > 16'h20}, 32'h1);
        conclude();
    end
endmodule : fgr_refresh_ctl_bench
`default_nettype wire
